//--- verilog/gtm_params.svh
`ifndef GTM_PARAMS_SVH
`define GTM_PARAMS_SVH

// Configuration register codes
`define GTM_CFG_JOIN_TMR 3'h0
`define GTM_CFG_JOIN_RTC 3'h1
`define GTM_CFG_SPLIT    3'h4

// Half mode field codes
`define GTM_MR_ONESHOT  2'h1
`define GTM_MR_PERIODIC 2'h2

// Reset, clock mode start and match wrap values
`define GTM_HALF_RST 16'hffff
`define GTM_PRE_RST  8'h00
`define GTM_RTC_INIT 32'h00000001
`define GTM_RTC_WRAP 32'h00000000

// Clock mode divider
`define GTM_RTC_IN_HZ  32768
`define GTM_RTC_OUT_HZ 1
`define GTM_RTC_DIV    (`GTM_RTC_IN_HZ / `GTM_RTC_OUT_HZ)

`endif

//--- verilog/gtm_pkg.sv
package gtm_pkg;

  typedef enum logic [1:0] {
    GTM_SPLIT,
    GTM_JOIN_TMR,
    GTM_JOIN_RTC
  } gtm_mode_t;

  typedef logic [15:0] gtm_half_t;

endpackage : gtm_pkg

//--- verilog/gtm_top.sv
// Function
// RQ1: Two 16-bit halves, split or joined 32-bit
// RQ2: Reset leaves block inactive, controls cleared
// RQ3: Reset sets counts, loads ones; prescale zero
// RQ4: Config 0 joined timer, 1 clock mode
// RQ5: Joined modes use only even capture pin
// RQ6: Joined acts as one timer; split independent
// RQ7: Joined load write fills both halves; here only in joined timer mode, clock mode ignores load writes
// RQ8: Joined count read is second:first half
// RQ9: Joined one-shot/periodic from first mode field
// RQ10: Enable counts down, reloads after zero
// RQ11: One-shot stops and clears enable; periodic continues
// RQ12: Zero sets raw time-out until cleared
// RQ13: Unmasked raw time-out sets masked flag
// RQ14: One-cycle trigger pulse when reaching zero
// RQ15: Load rewrite taken next cycle, continue
// RQ16: Stall bit freezes count until released
// RQ17: Clock mode up-counts, first loaded with one
// RQ18: 32.768 kHz pin divided to 1 Hz
// RQ19: Match rolls count to zero, keeps counting
// RQ20: Match sets raw, masked flags; clear bit
// RQ21: Clock enable bit overrides both stall bits; here only in joined modes, split halves still stall
// RQ22: Pinless instance makes internal interrupts only
// RQ23: Interrupt high while any masked flag set
`timescale 1ns/1ns
`include "gtm_params.svh"

module gtm_top
  import gtm_pkg::*;
#(
  parameter int RTC_DIV  = `GTM_RTC_DIV,
  parameter bit HAS_PINS = 1'b1
) (
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RST,
  input  wire logic [2:0]  I_CFG,
  input  wire logic [1:0]  I_MODE_A,
  input  wire logic [1:0]  I_MODE_B,
  input  wire logic        I_EN_SET_A,
  input  wire logic        I_EN_CLR_A,
  input  wire logic        I_EN_SET_B,
  input  wire logic        I_EN_CLR_B,
  input  wire logic        I_OTE_A,
  input  wire logic        I_OTE_B,
  input  wire logic        I_STALL_A,
  input  wire logic        I_STALL_B,
  input  wire logic        I_RTC_EN,
  input  wire logic        I_LOAD_WR_A,
  input  wire logic        I_LOAD_WR_B,
  input  wire logic [31:0] I_LOAD_DATA,
  input  wire logic        I_PRE_WR_A,
  input  wire logic        I_PRE_WR_B,
  input  wire logic [7:0]  I_PRE_DATA,
  input  wire logic        I_MATCH_WR,
  input  wire logic [31:0] I_MATCH_DATA,
  input  wire logic        I_MASK_TO_A,
  input  wire logic        I_MASK_TO_B,
  input  wire logic        I_MASK_RTC,
  input  wire logic        I_CLR_TO_A,
  input  wire logic        I_CLR_TO_B,
  input  wire logic        I_CLR_RTC,
  input  wire logic        I_CAPTURE_COMPARE_PIN_EVEN,
  output logic [31:0]      O_COUNT_A,
  output logic [15:0]      O_COUNT_B,
  output logic [7:0]       O_PRESCALE_A,
  output logic [7:0]       O_PRESCALE_B,
  output logic             O_EN_A,
  output logic             O_EN_B,
  output logic             O_RAW_TO_A,
  output logic             O_RAW_TO_B,
  output logic             O_RAW_RTC,
  output logic             O_MIS_TO_A,
  output logic             O_MIS_TO_B,
  output logic             O_MIS_RTC,
  output logic             O_TRIG_A,
  output logic             O_TRIG_B,
  output logic             O_IRQ
);

  localparam int DIV_W = (RTC_DIV > 2) ? $clog2(RTC_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(RTC_DIV - 1);

  generate
    if (RTC_DIV < 2) begin : g_bad_div
      $error("RTC_DIV must be at least 2");
    end
  endgenerate

  // Pin synchroniser, divider and tick
  logic             pin_s1_q, pin_s2_q, pin_s3_q;
  logic             pin_f_q, pin_f_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic             tick_q, tick_d;
  logic             pin_in;

  // Counter state
  gtm_mode_t   mode;
  gtm_half_t   cnt_q   [2];
  gtm_half_t   cnt_d   [2];
  gtm_half_t   ilr_q   [2];
  gtm_half_t   ilr_d   [2];
  logic [7:0]  pre_q   [2];
  logic [7:0]  pre_d   [2];
  logic [1:0]  en_q, en_d;
  logic [1:0]  rld_q, rld_d;
  logic [1:0]  to_q, to_d;
  logic [1:0]  mto_q, mto_d;
  logic [1:0]  trig_q, trig_d;
  logic        rtc_q, rtc_d;
  logic        mrtc_q, mrtc_d;
  logic        rinit_q, rinit_d;
  logic [31:0] match_q, match_d;
  logic [31:0] rda_q, rda_d;
  logic        irq_q, irq_d;

  logic [1:0]  en_set, en_clr, ote, stall, ld_wr, pre_wr, mask_to, clr_to, hit;
  logic [1:0]  mr     [2];
  logic [31:0] cnt32, nxt32;
  logic        freeze_a;

  assign en_set  = {I_EN_SET_B, I_EN_SET_A};
  assign en_clr  = {I_EN_CLR_B, I_EN_CLR_A};
  assign ote     = {I_OTE_B, I_OTE_A};
  assign stall   = {I_STALL_B, I_STALL_A};
  assign ld_wr   = {I_LOAD_WR_B, I_LOAD_WR_A};
  assign pre_wr  = {I_PRE_WR_B, I_PRE_WR_A};
  assign mask_to = {I_MASK_TO_B, I_MASK_TO_A};
  assign clr_to  = {I_CLR_TO_B, I_CLR_TO_A};
  assign mr[0]   = I_MODE_A;
  assign mr[1]   = I_MODE_B;
  assign pin_in  = HAS_PINS ? I_CAPTURE_COMPARE_PIN_EVEN : 1'b0; // see RQ22

  always_comb begin
    unique case (I_CFG)
      `GTM_CFG_JOIN_TMR: mode = GTM_JOIN_TMR; // see RQ4
      `GTM_CFG_JOIN_RTC: mode = GTM_JOIN_RTC; // see RQ4
      default:           mode = GTM_SPLIT;
    endcase
  end

  // Divider next state
  always_comb begin
    pin_f_d = pin_f_q;
    div_d   = div_q;
    tick_d  = 1'b0;
    if (pin_s2_q == pin_s3_q) begin
      pin_f_d = pin_s3_q;
    end
    if (mode != GTM_JOIN_RTC || !en_q[0]) begin
      div_d = '0;
    end else if (pin_f_d && !pin_f_q) begin // see RQ5
      if (div_q == DIV_LAST) begin // see RQ18
        div_d  = '0;
        tick_d = 1'b1;
      end else begin
        div_d = div_q + DIV_W'(1);
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
      pin_f_q  <= 1'b0;
      div_q    <= '0;
      tick_q   <= 1'b0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q  <= pin_f_d;
      div_q    <= div_d;
      tick_q   <= tick_d;
    end
  end

  // Counter next state
  always_comb begin
    cnt_d    = cnt_q;
    ilr_d    = ilr_q;
    pre_d    = pre_q;
    en_d     = en_q;
    rld_d    = 2'b00;
    hit      = 2'b00;
    rtc_d    = rtc_q;
    rinit_d  = rinit_q;
    match_d  = match_q;
    cnt32    = {cnt_q[1], cnt_q[0]};
    nxt32    = cnt32;
    freeze_a = stall[0] && !I_RTC_EN; // see RQ16, RQ21
    for (int h = 0; h < 2; h++) begin
      if (en_set[h]) begin
        en_d[h] = 1'b1;
      end
      if (en_clr[h]) begin
        en_d[h] = 1'b0;
      end
      if (pre_wr[h]) begin
        pre_d[h] = I_PRE_DATA;
      end
    end
    if (I_MATCH_WR) begin
      match_d = I_MATCH_DATA; // see RQ19
    end
    unique case (mode)
      GTM_JOIN_TMR: begin
        en_d[1] = 1'b0; // see RQ6
        if (I_LOAD_WR_A) begin
          ilr_d[0] = I_LOAD_DATA[15:0];  // see RQ7
          ilr_d[1] = I_LOAD_DATA[31:16]; // see RQ7
          nxt32    = I_LOAD_DATA;        // see RQ15
        end else if (rld_q[0]) begin
          nxt32 = {ilr_q[1], ilr_q[0]}; // see RQ10
        end else if (en_q[0] && !freeze_a && cnt32 != 32'h00000000) begin
          nxt32 = cnt32 - 32'h00000001; // see RQ10
          if (nxt32 == 32'h00000000) begin
            hit[0]   = 1'b1;
            rld_d[0] = 1'b1;
            if (I_MODE_A == `GTM_MR_ONESHOT) begin // see RQ9
              en_d[0] = 1'b0; // see RQ11
            end
          end
        end
        cnt_d[0] = nxt32[15:0];
        cnt_d[1] = nxt32[31:16];
      end
      GTM_JOIN_RTC: begin
        en_d[1] = 1'b0; // see RQ6
        if (!rinit_q) begin
          nxt32   = `GTM_RTC_INIT; // see RQ17
          rinit_d = 1'b1;
        end else if (en_q[0] && tick_q && !freeze_a) begin
          if (cnt32 == match_q) begin
            nxt32 = `GTM_RTC_WRAP; // see RQ19
            rtc_d = 1'b1;          // see RQ20
          end else begin
            nxt32 = cnt32 + 32'h00000001; // see RQ17
          end
        end
        cnt_d[0] = nxt32[15:0];
        cnt_d[1] = nxt32[31:16];
      end
      GTM_SPLIT: begin
        for (int h = 0; h < 2; h++) begin // see RQ1, RQ6
          if (ld_wr[h]) begin
            ilr_d[h] = I_LOAD_DATA[15:0];
            cnt_d[h] = I_LOAD_DATA[15:0]; // see RQ15
          end else if (rld_q[h]) begin
            cnt_d[h] = ilr_q[h];
          end else if (en_q[h] && !stall[h] && cnt_q[h] != 16'h0000) begin
            cnt_d[h] = cnt_q[h] - 16'h0001;
            if (cnt_d[h] == 16'h0000) begin
              hit[h]   = 1'b1;
              rld_d[h] = 1'b1;
              if (mr[h] == `GTM_MR_ONESHOT) begin
                en_d[h] = 1'b0;
              end
            end
          end
        end
      end
    endcase
    if (I_CLR_RTC) begin
      rtc_d = 1'b0;
    end
    if (mode == GTM_JOIN_RTC && rinit_q && en_q[0] && tick_q && !freeze_a
        && cnt32 == match_q) begin
      rtc_d = 1'b1; // see RQ20
    end
    for (int h = 0; h < 2; h++) begin
      to_d[h]   = hit[h] || (to_q[h] && !clr_to[h]); // see RQ12
      trig_d[h] = hit[h] && ote[h];                  // see RQ14
    end
    mto_d  = to_d & mask_to;       // see RQ13
    mrtc_d = rtc_d && I_MASK_RTC;  // see RQ20
    irq_d  = (|mto_d) || mrtc_d;   // see RQ23
    if (mode == GTM_SPLIT) begin
      rda_d = {16'h0000, cnt_d[0]};
    end else begin
      rda_d = {cnt_d[1], cnt_d[0]}; // see RQ8
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      for (int h = 0; h < 2; h++) begin
        cnt_q[h] <= `GTM_HALF_RST; // see RQ3
        ilr_q[h] <= `GTM_HALF_RST; // see RQ3
        pre_q[h] <= `GTM_PRE_RST;  // see RQ3
      end
      en_q    <= 2'b00; // see RQ2
      rld_q   <= 2'b00;
      to_q    <= 2'b00;
      mto_q   <= 2'b00;
      trig_q  <= 2'b00;
      rtc_q   <= 1'b0;
      mrtc_q  <= 1'b0;
      rinit_q <= 1'b0;
      match_q <= 32'hffffffff;
      rda_q   <= {16'h0000, `GTM_HALF_RST};
      irq_q   <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      ilr_q   <= ilr_d;
      pre_q   <= pre_d;
      en_q    <= en_d;
      rld_q   <= rld_d;
      to_q    <= to_d;
      mto_q   <= mto_d;
      trig_q  <= trig_d;
      rtc_q   <= rtc_d;
      mrtc_q  <= mrtc_d;
      rinit_q <= rinit_d;
      match_q <= match_d;
      rda_q   <= rda_d;
      irq_q   <= irq_d;
    end
  end

  assign O_COUNT_A    = rda_q;
  assign O_COUNT_B    = cnt_q[1];
  assign O_PRESCALE_A = pre_q[0];
  assign O_PRESCALE_B = pre_q[1];
  assign O_EN_A       = en_q[0];
  assign O_EN_B       = en_q[1];
  assign O_RAW_TO_A   = to_q[0];
  assign O_RAW_TO_B   = to_q[1];
  assign O_RAW_RTC    = rtc_q;
  assign O_MIS_TO_A   = mto_q[0];
  assign O_MIS_TO_B   = mto_q[1];
  assign O_MIS_RTC    = mrtc_q;
  assign O_TRIG_A     = trig_q[0];
  assign O_TRIG_B     = trig_q[1];
  assign O_IRQ        = irq_q;

endmodule : gtm_top

//--- test/gtm_top_asserts.sv
`timescale 1ns/1ns
module gtm_top_asserts
  import gtm_pkg::*;
(
  input wire logic        I_REF_CLK,
  input wire logic        I_RST,
  input wire logic [2:0]  I_CFG,
  input wire logic [1:0]  I_MODE_A,
  input wire logic        I_EN_CLR_A,
  input wire logic        I_STALL_A,
  input wire logic        I_RTC_EN,
  input wire logic        I_LOAD_WR_A,
  input wire logic [31:0] I_LOAD_DATA,
  input wire logic        I_CLR_TO_A,
  input wire logic [31:0] O_COUNT_A,
  input wire logic        O_EN_A,
  input wire logic        O_EN_B,
  input wire logic        O_RAW_TO_A,
  input wire logic        O_MIS_TO_A,
  input wire logic        O_MIS_TO_B,
  input wire logic        O_MIS_RTC,
  input wire logic        O_TRIG_A,
  input wire logic        O_IRQ
);
  wire j = I_CFG == 3'h0;
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RST);
  a_trig_zero: assert property (O_TRIG_A |-> O_COUNT_A == 32'h0)
    else $error("trigger away from zero");
  a_trig_pulse: assert property (O_TRIG_A |=> !O_TRIG_A)
    else $error("trigger longer than one cycle");
  a_mis_raw: assert property (O_MIS_TO_A |-> O_RAW_TO_A)
    else $error("masked flag without raw flag");
  a_irq_any: assert property (O_IRQ == (O_MIS_TO_A || O_MIS_TO_B || O_MIS_RTC))
    else $error("interrupt differs from masked flags");
  a_raw_hold: assert property ($fell(O_RAW_TO_A) |-> $past(I_CLR_TO_A))
    else $error("raw flag dropped without clear");
  a_stall_hold: assert property (j && $past(j && I_STALL_A && !I_RTC_EN)
    && !$past(I_LOAD_WR_A) |-> $stable(O_COUNT_A))
    else $error("count moved while stalled");
  a_load_take: assert property (j && $past(j && I_LOAD_WR_A)
    |-> O_COUNT_A == $past(I_LOAD_DATA))
    else $error("load not taken next cycle");
  a_count_dec: assert property (j && $past(j && O_EN_A && !I_STALL_A && !I_LOAD_WR_A
    && !I_EN_CLR_A && O_COUNT_A != 32'h0) |-> O_COUNT_A == $past(O_COUNT_A) - 32'h1)
    else $error("count did not step down");
  a_oneshot_off: assert property (j && $past(j && O_EN_A && I_MODE_A == 2'h1
    && !I_STALL_A && !I_LOAD_WR_A && O_COUNT_A == 32'h1) |-> !O_EN_A)
    else $error("one-shot kept enable");
  a_en_b_join: assert property (I_CFG < 3'h2 && $past(I_CFG < 3'h2) |-> !O_EN_B)
    else $error("second half enabled in joined mode");
endmodule : gtm_top_asserts

bind gtm_top gtm_top_asserts gtm_top_asserts_inst (
  .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_CFG(I_CFG), .I_MODE_A(I_MODE_A),
  .I_EN_CLR_A(I_EN_CLR_A), .I_STALL_A(I_STALL_A), .I_RTC_EN(I_RTC_EN),
  .I_LOAD_WR_A(I_LOAD_WR_A), .I_LOAD_DATA(I_LOAD_DATA), .I_CLR_TO_A(I_CLR_TO_A),
  .O_COUNT_A(O_COUNT_A), .O_EN_A(O_EN_A), .O_EN_B(O_EN_B), .O_RAW_TO_A(O_RAW_TO_A),
  .O_MIS_TO_A(O_MIS_TO_A), .O_MIS_TO_B(O_MIS_TO_B), .O_MIS_RTC(O_MIS_RTC),
  .O_TRIG_A(O_TRIG_A), .O_IRQ(O_IRQ));

//--- test/gtm_top_tb.sv
`timescale 1ns/1ns
module gtm_top_tb
  import gtm_pkg::*;
;
  localparam logic [20:0] ESA = 21'h1, ECA = 21'h2, ESB = 21'h4, ECB = 21'h8, OTA = 21'h10;
  localparam logic [20:0] OTB = 21'h20, STA = 21'h40, STB = 21'h80, RTE = 21'h100;
  localparam logic [20:0] LWA = 21'h200, LWB = 21'h400, PWA = 21'h800, PWB = 21'h1000;
  localparam logic [20:0] MWR = 21'h2000, CTA = 21'h4000, CTB = 21'h8000, CRT = 21'h10000;
  localparam logic [20:0] MKA = 21'h20000, MKB = 21'h40000, MKR = 21'h80000, PIN = 21'h100000;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  cfg = 3'h0;
  logic [1:0]  ma = 2'h0, mb = 2'h0;
  logic [20:0] p = 21'h0;
  logic [31:0] d = 32'h0, ca, v;
  logic [15:0] cb;
  logic [7:0]  pa, pb;
  logic        ea, eb, ra, rb, rr, mia, mib, mr, ta, tb, irq;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          i;
  logic [47:0] rows [4] = '{48'h12345678_1234, 48'hffff0000_ffff, 48'h0000ffff_0000,
                            48'h00000003_0000};
  gtm_top #(.RTC_DIV(4), .HAS_PINS(1'b1)) gtm_top_inst (
    .I_REF_CLK(clk), .I_RST(rst), .I_CFG(cfg), .I_MODE_A(ma), .I_MODE_B(mb),
    .I_EN_SET_A(p[0]), .I_EN_CLR_A(p[1]), .I_EN_SET_B(p[2]), .I_EN_CLR_B(p[3]),
    .I_OTE_A(p[4]), .I_OTE_B(p[5]), .I_STALL_A(p[6]), .I_STALL_B(p[7]), .I_RTC_EN(p[8]),
    .I_LOAD_WR_A(p[9]), .I_LOAD_WR_B(p[10]), .I_LOAD_DATA(d), .I_PRE_WR_A(p[11]),
    .I_PRE_WR_B(p[12]), .I_PRE_DATA(d[7:0]), .I_MATCH_WR(p[13]), .I_MATCH_DATA(d),
    .I_MASK_TO_A(p[17]), .I_MASK_TO_B(p[18]), .I_MASK_RTC(p[19]), .I_CLR_TO_A(p[14]),
    .I_CLR_TO_B(p[15]), .I_CLR_RTC(p[16]), .I_CAPTURE_COMPARE_PIN_EVEN(p[20]), .O_COUNT_A(ca),
    .O_COUNT_B(cb), .O_PRESCALE_A(pa), .O_PRESCALE_B(pb), .O_EN_A(ea), .O_EN_B(eb),
    .O_RAW_TO_A(ra), .O_RAW_TO_B(rb), .O_RAW_RTC(rr), .O_MIS_TO_A(mia), .O_MIS_TO_B(mib),
    .O_MIS_RTC(mr), .O_TRIG_A(ta), .O_TRIG_B(tb), .O_IRQ(irq));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic step(input logic [20:0] s, input logic [31:0] x = 32'h0);
    @(posedge clk);
    p <= s;
    d <= x;
    #1;
  endtask : step
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic tmo(input int k);
    if (k >= 300) begin
      error_cnt++;
      print_verdict();
    end
  endtask : tmo
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    step(21'h0);
    chk(ca, 32'hffffffff, "ca");
    chk(cb, 32'hffff, "cb");
    chk(pa, 32'h0, "pa");
    chk(ea | eb | irq, 32'h0, "ctl");
    $display("reset test done");
    for (i = 0; i < 4; i++) begin
      step(LWA | ESB | LWB, rows[i][47:16]);
      step(21'h0);
      chk(ca, rows[i][47:16], "ca");
      chk(cb, rows[i][15:0], "cb");
      chk(eb, 32'h0, "eb");
    end
    @(posedge clk);
    ma <= 2'h1;
    step(OTA | MKA | ESA);
    for (i = 0; i < 300 && ta !== 1'b1; i++) step(OTA | MKA);
    tmo(i);
    chk(ca, 32'h0, "ca");
    chk({ra, mia, irq, ea}, 32'he, "flags");
    step(OTA | MKA);
    chk({ta, ca[30:0]}, 32'h3, "reload");
    repeat (2) step(MKA);
    chk({ra, ca[30:0]}, 32'h80000003, "stop");
    step(MKA | CTA);
    repeat (2) step(MKA);
    chk({ra, irq}, 32'h0, "clear");
    $display("one-shot test done");
    @(posedge clk);
    ma <= 2'h2;
    step(LWA, 32'h5);
    step(ESA);
    step(21'h0);
    step(STA);
    v = ca;
    repeat (3) step(STA);
    chk(ca, v, "stall");
    repeat (2) step(21'h0);
    chk(ca, v - 32'h1, "resume");
    step(LWA, 32'h9);
    step(21'h0);
    chk(ca, 32'h9, "rewrite");
    for (i = 0; i < 300 && ra !== 1'b1; i++) step(21'h0);
    tmo(i);
    chk(ea, 32'h1, "periodic_en");
    repeat (2) step(ECA | CTA);
    chk({ea, ca[30:0]}, 32'h8, "periodic");
    $display("periodic test done");
    @(posedge clk);
    cfg <= 3'h4;
    mb <= 2'h1;
    step(LWB | PWA, 32'h3);
    step(ESB | OTB | MKB | PWB, 32'h81);
    for (i = 0; i < 300 && tb !== 1'b1; i++) step(OTB | MKB);
    tmo(i);
    chk({rb, mib, eb, cb}, 32'h60000, "split");
    chk({ca[31:16], pa, pb}, 32'h0381, "halves");
    step(MKB | CTB | ECB);
    repeat (2) step(MKB);
    chk({rb, irq}, 32'h0, "clear_b");
    $display("split test done");
    @(posedge clk);
    rst <= 1'b1;
    cfg <= 3'h1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) step(21'h0);
    chk(ca, 32'h1, "rtc_init");
    step(MWR | MKR, 32'h2);
    step(MKR | RTE | ESA);
    for (i = 0; i < 300 && rr !== 1'b1; i++) step(MKR | RTE | STA | STB | (i[2] ? PIN : 21'h0));
    tmo(i);
    chk(i >= 60 && i < 90, 32'h1, "rtc_rate");
    chk({mr, irq}, 32'h3, "rtc_flags");
    chk(ca, 32'h0, "rtc_wrap");
    step(MKR | RTE | CRT);
    repeat (2) step(MKR | RTE);
    chk({rr, mr, irq}, 32'h0, "rtc_clear");
    $display("clock mode test done");
    print_verdict();
  end
endmodule : gtm_top_tb
